// file: rtl/abwf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Word FIFO
// ----------------------------------------
module abwf_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, rd_reg;
	logic [AW:0] cnt_reg;
	wire do_wr = i_in_valid && o_in_ready;
	wire do_rd = o_out_valid && i_out_ready;
	assign o_in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign o_out_valid = cnt_reg != '0;
	assign o_out_data = mem[rd_reg];
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= do_wr ? AW'(wr_reg + 1'b1) : wr_reg;
			rd_reg <= do_rd ? AW'(rd_reg + 1'b1) : rd_reg;
			cnt_reg <= (AW+1)'(cnt_reg + do_wr - do_rd);
		end
	end
	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem[wr_reg] <= i_in_data;
		end
	end
endmodule

// ----------------------------------------
// Formatter top
// ----------------------------------------
module abwf_formatter (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_mil_valid,
	input wire abwf_pkg::abwf_mil_type i_mil,
	output logic o_mil_ready,
	input wire logic i_arinc_valid,
	input wire abwf_pkg::abwf_arinc_type i_arinc,
	output logic o_arinc_ready,
	input wire logic i_aux_valid,
	input wire abwf_pkg::abwf_aux_type i_aux,
	output logic o_aux_ready,
	input wire abwf_pkg::abwf_time_type i_time,
	input wire logic i_mil_ttag_en,
	input wire logic i_arinc_ttag_en,
	input wire logic i_resp_en,
	output logic o_fmt_valid,
	output abwf_pkg::abwf_fmt_type o_fmt_word,
	input wire logic i_fmt_ready
);
	abwf_pkg::abwf_fmt_type buf_reg [abwf_pkg::BUF_N];
	abwf_pkg::abwf_fmt_type bld [abwf_pkg::BUF_N];
	logic [2:0] bld_len;
	logic [2:0] idx_reg, len_reg, turn_reg, rdy_reg;
	logic [2:0] idx_next, rdy_next, turn_next;
	logic fifo_in_ready, fifo_out_valid, fmt_valid_reg;
	logic [23:0] fifo_out_data;
	abwf_pkg::abwf_fmt_type fmt_word_reg;

	// ----------------------------------------
	// Acceptance, one source at a time
	// ----------------------------------------
	wire acc_mil = i_mil_valid && rdy_reg[0];
	wire acc_arinc = i_arinc_valid && rdy_reg[1];
	wire acc_aux = i_aux_valid && rdy_reg[2];
	wire acc_any = acc_mil || acc_arinc || acc_aux;
	wire idle = idx_reg == len_reg;
	wire push_v = !idle;
	wire push = push_v && fifo_in_ready;
	wire abwf_pkg::abwf_fmt_type push_w = buf_reg[idx_reg];

	// ----------------------------------------
	// 1553 decode
	// ----------------------------------------
	wire [15:0] mil_info = i_mil.raw[abwf_pkg::RAW_INFO_MSB:abwf_pkg::RAW_INFO_LSB];
	wire [3:0] mil_grp = i_mil.bus_b ? abwf_pkg::GRP_BUS_B : abwf_pkg::GRP_BUS_A;
	wire [3:0] mil_err_lbl = i_mil.bus_b ? abwf_pkg::LBL_ERR_B : abwf_pkg::LBL_ERR_A;
	wire [3:0] mil_kind_lbl = (i_mil.kind == abwf_pkg::KIND_CMD) ? abwf_pkg::LBL_CMD :
		(i_mil.kind == abwf_pkg::KIND_STAT) ? abwf_pkg::LBL_STAT : abwf_pkg::LBL_DATA;
	wire [3:0] mil_lbl = i_mil.err ? mil_err_lbl : mil_kind_lbl;
	wire mil_resp = i_resp_en && i_mil.resp_ok && i_mil.kind == abwf_pkg::KIND_STAT && !i_mil.err;
	wire mil_tag = i_mil_ttag_en && i_mil.first_cmd && i_mil.kind == abwf_pkg::KIND_CMD;

	// ----------------------------------------
	// 429 and auxiliary decode
	// ----------------------------------------
	wire [1:0] ar_sub = i_arinc.chan[1:0];
	wire [3:0] ar_grp = i_arinc.chan[5:2];
	wire [3:0] ar_hi_lbl = HI_LBL_TBL_SEL(ar_sub);
	wire [3:0] ar_lo_lbl = LO_LBL_TBL_SEL(ar_sub);
	wire ar_err = i_arinc.par_err || i_arinc.cnt_err;
	wire [7:0] ar_diag = {6'h00, i_arinc.par_err, i_arinc.cnt_err};
	wire [3:0] aux_lbl = (i_resp_en && i_aux.label == abwf_pkg::LBL_RESP) ?
		abwf_pkg::LBL_AUX : i_aux.label;

	function automatic logic [3:0] HI_LBL_TBL_SEL(input logic [1:0] s);
		HI_LBL_TBL_SEL = abwf_pkg::HI_LBL_TBL[{s, 2'b00} +: 4];
	endfunction
	function automatic logic [3:0] LO_LBL_TBL_SEL(input logic [1:0] s);
		LO_LBL_TBL_SEL = abwf_pkg::LO_LBL_TBL[{s, 2'b00} +: 4];
	endfunction

	// ----------------------------------------
	// Word list for the accepted event
	// ----------------------------------------
	always_comb begin
		automatic int n = 0;
		automatic logic [3:0] g = 4'h0;
		for (int k = 0; k < abwf_pkg::BUF_N; k++) begin
			bld[k] = '0;
		end
		if (acc_mil) begin
			g = mil_grp;
			if (mil_resp) begin
				bld[n] = '{g, abwf_pkg::LBL_RESP, i_mil.resp};
				n++;
			end
			bld[n] = '{g, mil_lbl, mil_info};
			n++;
			if (mil_tag) begin
				bld[n] = '{g, abwf_pkg::LBL_T_HI, i_time.hi};
				bld[n+1] = '{g, abwf_pkg::LBL_T_LO, i_time.lo};
				bld[n+2] = '{g, abwf_pkg::LBL_T_US, i_time.us};
				n += 3;
			end
		end else if (acc_arinc) begin
			g = ar_grp;
			if (ar_err) begin
				bld[n] = '{g, abwf_pkg::LBL_ARINC_ERR, {ar_hi_lbl, ar_lo_lbl, ar_diag}};
				n++;
			end
			bld[n] = '{g, ar_hi_lbl, i_arinc.word[31:16]};
			bld[n+1] = '{g, ar_lo_lbl, i_arinc.word[15:0]};
			n += 2;
			if (i_arinc_ttag_en) begin
				bld[n] = '{g, abwf_pkg::LBL_T_HI, i_time.hi};
				bld[n+1] = '{g, abwf_pkg::LBL_T_LO, i_time.lo};
				bld[n+2] = '{g, abwf_pkg::LBL_T_US, i_time.us};
				n += 3;
			end
		end else if (acc_aux) begin
			bld[0] = '{i_aux.group, aux_lbl, i_aux.data};
			n = 1;
		end
		bld_len = 3'(n);
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	wire last_push = push && (3'(idx_reg + 1'b1) == len_reg);
	wire idle_next = !acc_any && (idle || last_push);
	assign idx_next = acc_any ? 3'h0 : push ? 3'(idx_reg + 1'b1) : idx_reg;
	assign turn_next = {turn_reg[1:0], turn_reg[2]};
	assign rdy_next = idle_next ? turn_next : abwf_pkg::RDY_RST;

	for (genvar e = 0; e < abwf_pkg::BUF_N; e++) begin : g_buf
		always_ff @(posedge i_clk) begin
			if (acc_any) begin
				buf_reg[e] <= bld[e];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idx_reg <= abwf_pkg::IDX_RST;
			len_reg <= abwf_pkg::IDX_RST;
			turn_reg <= abwf_pkg::TURN_RST;
			rdy_reg <= abwf_pkg::RDY_RST;
		end else begin
			idx_reg <= idx_next;
			len_reg <= acc_any ? bld_len : len_reg;
			turn_reg <= turn_next;
			rdy_reg <= rdy_next;
		end
	end

	// ----------------------------------------
	// Output buffering, monitor only: nothing goes back to the buses
	// ----------------------------------------
	wire out_take = !fmt_valid_reg || i_fmt_ready;
	abwf_fifo #(
		.WIDTH(24),
		.DEPTH(abwf_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(push_v),
		.i_in_data(push_w),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(out_take)
	);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fmt_valid_reg <= 1'b0;
			fmt_word_reg <= '0;
		end else if (out_take) begin
			fmt_valid_reg <= fifo_out_valid;
			fmt_word_reg <= fifo_out_data;
		end
	end
	assign o_fmt_valid = fmt_valid_reg;
	assign o_fmt_word = fmt_word_reg;
	assign o_mil_ready = rdy_reg[0];
	assign o_arinc_ready = rdy_reg[1];
	assign o_aux_ready = rdy_reg[2];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	chk_mil_bit_map: assert property (acc_mil && !mil_resp |=>
		buf_reg[0].info == $past(i_mil.raw[16:1]))
		else $error("1553 info field misplaced");
	chk_mil_err_label: assert property (acc_mil && i_mil.err |=>
		buf_reg[0].label == ($past(i_mil.bus_b) ? 4'h8 : 4'hc))
		else $error("1553 error label wrong");
	chk_mil_time_order: assert property (acc_mil && mil_tag && !mil_resp |=>
		len_reg == 3'h4 && buf_reg[1].label == abwf_pkg::LBL_T_HI &&
		buf_reg[2].label == abwf_pkg::LBL_T_LO && buf_reg[3].label == abwf_pkg::LBL_T_US)
		else $error("1553 time words missing or out of order");
	chk_resp_first: assert property (acc_mil && mil_resp |=>
		buf_reg[0].label == abwf_pkg::LBL_RESP && buf_reg[1].label == abwf_pkg::LBL_STAT)
		else $error("Response word not before status");
	chk_arinc_split: assert property (acc_arinc && !ar_err |=>
		buf_reg[0].info == $past(i_arinc.word[31:16]) &&
		buf_reg[1].info == $past(i_arinc.word[15:0]))
		else $error("429 half words wrong");
	chk_arinc_err_word: assert property (acc_arinc && ar_err |=>
		buf_reg[0].label == 4'h4 && buf_reg[0].group == $past(i_arinc.chan[5:2]) &&
		buf_reg[0].info[15:8] == {buf_reg[1].label, buf_reg[2].label})
		else $error("429 error word malformed");
	chk_arinc_time: assert property (acc_arinc && i_arinc_ttag_en && !ar_err |=>
		len_reg == 3'h5 && buf_reg[2].label == abwf_pkg::LBL_T_HI)
		else $error("429 time words misplaced");
	chk_stall_hold: assert property (push_v && !fifo_in_ready |=>
		$stable(idx_reg) && push_v)
		else $error("Word dropped under back-pressure");
	chk_one_grant: assert property (
		$onehot0(rdy_reg) && (rdy_reg == 3'h0 || idle))
		else $error("Grant while busy");
	chk_out_hold: assert property (o_fmt_valid && !i_fmt_ready |=>
		o_fmt_valid && $stable(o_fmt_word))
		else $error("Output word changed while stalled");

	chk_mil_group: assert property (acc_mil |=>
		buf_reg[0].group == ($past(i_mil.bus_b) ? abwf_pkg::GRP_BUS_B : abwf_pkg::GRP_BUS_A))
		else $error("1553 group label wrong");
	chk_mil_plain_len: assert property (acc_mil && !mil_tag && !mil_resp |=>
		len_reg == 3'h1)
		else $error("1553 word count wrong");
	chk_mil_time_val: assert property (acc_mil && mil_tag && !mil_resp |=>
		buf_reg[1].info == $past(i_time.hi) && buf_reg[2].info == $past(i_time.lo) &&
		buf_reg[3].info == $past(i_time.us))
		else $error("1553 time values wrong");
	chk_arinc_raw: assert property (acc_arinc && ar_err |=>
		buf_reg[1].info == $past(i_arinc.word[31:16]) &&
		buf_reg[2].info == $past(i_arinc.word[15:0]))
		else $error("429 raw half words after error wrong");
	chk_half_distinct: assert property (acc_arinc && !ar_err |=>
		buf_reg[0].label != buf_reg[1].label && buf_reg[0].group == buf_reg[1].group)
		else $error("429 half word labels not distinct");
	chk_arinc_group: assert property (acc_arinc |=>
		buf_reg[0].group == $past(i_arinc.chan[5:2]))
		else $error("429 group label wrong");
	chk_aux_label: assert property (acc_aux |=>
		len_reg == 3'h1 && buf_reg[0].label == (($past(i_resp_en) &&
		$past(i_aux.label) == abwf_pkg::LBL_RESP) ? abwf_pkg::LBL_AUX : $past(i_aux.label)))
		else $error("Auxiliary label wrong");
	chk_push_step: assert property (push |=>
		idx_reg == 3'($past(idx_reg) + 1'b1))
		else $error("Push index skipped");

	cov_mil_tagged: cover property (acc_mil && mil_tag ##[1:20] last_push);
	cov_arinc_err: cover property (acc_arinc && ar_err);
	cov_resp: cover property (acc_mil && mil_resp);
	cov_fifo_full: cover property (push_v && !fifo_in_ready);
	cov_aux_relabel: cover property (acc_aux && i_resp_en && i_aux.label == abwf_pkg::LBL_RESP);
endmodule
`default_nettype wire

// file: rtl/abwf_pkg.sv
// Summary of operation
// - Every formatted output word is 24 bits
// - Drop 1553 sync and parity bits
// - 1553, auxiliary and time words get content labels
// - 1553 bit four lands in bit nine
// - 1553 error label 1100 bus A, 1000 B
// - 1553 error word carries stripped 16-bit pattern
// - Time words follow first command, high-low-microsecond
// - Response time word precedes its status word
// - Label 0100 free for user inputs otherwise
// - 429 side only receives, never transmits
// - Up to 64 receive channels addressed
// - Four channels share a group label
// - 429 syllables, auxiliary, time words get labels
// - Split 32-bit word into two syllables
// - Only parity and bit-count faults are errors
// - 429 error word: group, 0100, syllable labels
// - Syllables after error carry raw faulty data
// - 429 time words follow the low syllable
// - 1553 side passively monitors both buses
// - Only word-structure faults count as errors
// - Output keeps bus word arrival order
// - Bit 1 is the MSB, sent first
package abwf_pkg;
	localparam logic [3:0] LBL_CMD = 4'h1;
	localparam logic [3:0] LBL_STAT = 4'h2;
	localparam logic [3:0] LBL_DATA = 4'h3;
	localparam logic [3:0] LBL_RESP = 4'h4;
	localparam logic [3:0] LBL_ARINC_ERR = 4'h4;
	localparam logic [3:0] LBL_T_HI = 4'h5;
	localparam logic [3:0] LBL_T_LO = 4'h6;
	localparam logic [3:0] LBL_T_US = 4'h7;
	localparam logic [3:0] LBL_AUX = 4'h9;
	localparam logic [3:0] LBL_ERR_A = 4'hc;
	localparam logic [3:0] LBL_ERR_B = 4'h8;
	localparam logic [3:0] GRP_BUS_A = 4'h0;
	localparam logic [3:0] GRP_BUS_B = 4'h1;
	// Upper and lower half word labels per channel within a group
	localparam logic [15:0] HI_LBL_TBL = 16'hd961;
	localparam logic [15:0] LO_LBL_TBL = 16'hea72;
	localparam int RAW_INFO_MSB = 16;
	localparam int RAW_INFO_LSB = 1;
	localparam int FIFO_DEPTH = 8;
	localparam int BUF_N = 6;
	localparam logic [2:0] IDX_RST = 3'h0;
	localparam logic [2:0] TURN_RST = 3'h1;
	localparam logic [2:0] RDY_RST = 3'h0;
	typedef enum logic [1:0] {KIND_CMD, KIND_STAT, KIND_DATA} abwf_kind_type;
	typedef struct packed {
		logic [3:0] group;
		logic [3:0] label;
		logic [15:0] info;
	} abwf_fmt_type;
	typedef struct packed {
		abwf_kind_type kind;
		logic bus_b;
		logic first_cmd;
		logic err;
		logic [19:0] raw;
		logic resp_ok;
		logic [15:0] resp;
	} abwf_mil_type;
	typedef struct packed {
		logic [5:0] chan;
		logic [31:0] word;
		logic par_err;
		logic cnt_err;
	} abwf_arinc_type;
	typedef struct packed {
		logic [3:0] group;
		logic [3:0] label;
		logic [15:0] data;
	} abwf_aux_type;
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] us;
	} abwf_time_type;
endpackage

// file: dv/abwf_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Downstream sink model
// ----------------------------------------
module abwf_sink (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_stall,
	input wire logic i_slow,
	input wire logic i_valid,
	output logic o_ready,
	output logic o_take
);
	logic ph_reg;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ph_reg <= 1'b0;
		end else begin
			ph_reg <= ~ph_reg;
		end
	end
	// Slow mode takes a word on alternate cycles only
	assign o_ready = !i_stall && (!i_slow || ph_reg);
	assign o_take = i_valid && o_ready;
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk, rst, mt, at, re, stall, slow, take, f_rdy, f_vld;
	logic [2:0] vld;
	wire [2:0] rdy;
	abwf_pkg::abwf_mil_type i_mil;
	abwf_pkg::abwf_arinc_type i_ar;
	abwf_pkg::abwf_aux_type i_ax;
	abwf_pkg::abwf_fmt_type o_word;
	logic [23:0] got[$];
	logic [23:0] exq[$];
	int n_fail = 0;
	int checks = 0;
	abwf_pkg::abwf_time_type tm;
	abwf_formatter uut (.i_clk(i_clk), .i_sys_rst(rst), .i_mil_valid(vld[0]), .i_mil(i_mil),
		.o_mil_ready(rdy[0]), .i_arinc_valid(vld[1]), .i_arinc(i_ar), .o_arinc_ready(rdy[1]),
		.i_aux_valid(vld[2]), .i_aux(i_ax), .o_aux_ready(rdy[2]), .i_time(tm),
		.i_mil_ttag_en(mt), .i_arinc_ttag_en(at), .i_resp_en(re), .o_fmt_valid(f_vld),
		.o_fmt_word(o_word), .i_fmt_ready(f_rdy));
	abwf_sink sink (.i_clk(i_clk), .i_sys_rst(rst), .i_stall(stall), .i_slow(slow),
		.i_valid(f_vld), .o_ready(f_rdy), .o_take(take));
	always #20 i_clk = ~i_clk;
	always @(negedge i_clk) begin
		if (take) got.push_back(o_word);
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [23:0] g, input logic [23:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task ex(input logic [3:0] g, input logic [3:0] l, input logic [15:0] d);
		exq.push_back({g, l, d});
	endtask
	task ext(input logic [3:0] g);
		ex(g, 4'h5, tm.hi);
		ex(g, 4'h6, tm.lo);
		ex(g, 4'h7, tm.us);
	endtask
	task send(input int s);
		int n;
		begin
			n = 0;
			@(posedge i_clk);
			#1;
			vld = 3'h1 << s;
			while (!rdy[s] && n < 300) begin
				@(posedge i_clk);
				#1;
				n++;
			end
			@(posedge i_clk);
			#1;
			vld = 3'h0;
		end
	endtask
	task mil(input abwf_pkg::abwf_kind_type k, input logic b, f, e, input logic [15:0] d);
		logic [3:0] g;
		begin
			g = {3'h0, b};
			i_mil = '{k, b, f, e, {3'h5, d, 1'b1}, 1'b1, 16'h0023};
			if (!e && re && k == abwf_pkg::KIND_STAT) ex(g, 4'h4, 16'h0023);
			if (e) ex(g, b ? 4'h8 : 4'hc, d);
			else ex(g, {2'h0, k} + 4'h1, d);
			if (mt && f && k == abwf_pkg::KIND_CMD) ext(g);
			send(0);
		end
	endtask
	task arn(input logic [5:0] c, input logic [31:0] w, input logic pe, ce);
		logic [3:0] h, l;
		begin
			h = abwf_pkg::HI_LBL_TBL[4*c[1:0] +: 4];
			l = abwf_pkg::LO_LBL_TBL[4*c[1:0] +: 4];
			i_ar = '{c, w, pe, ce};
			if (pe || ce) ex(c[5:2], 4'h4, {h, l, 6'h0, pe, ce});
			ex(c[5:2], h, w[31:16]);
			ex(c[5:2], l, w[15:0]);
			if (at) ext(c[5:2]);
			send(1);
		end
	endtask
	task aux(input logic [3:0] l);
		i_ax = '{4'h2, l, 16'hbeef};
		ex(4'h2, (re && l == 4'h4) ? 4'h9 : l, 16'hbeef);
		send(2);
	endtask
	task done(input string nm);
		int n;
		begin
			n = 0;
			while (got.size() < exq.size() && n < 600) begin
				@(posedge i_clk);
				n++;
			end
			repeat (6) @(posedge i_clk);
			#1;
			chk(24'(got.size()), 24'(exq.size()));
			foreach (exq[k]) if (k < got.size()) chk(got[k], exq[k]);
			$display("test %s done", nm);
			got.delete();
			exq.delete();
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_mil;
		mt = 1'b1;
		mil(abwf_pkg::KIND_CMD, 1'b0, 1'b1, 1'b0, 16'h9c3e);
		mil(abwf_pkg::KIND_DATA, 1'b0, 1'b0, 1'b0, 16'h0001);
		mil(abwf_pkg::KIND_CMD, 1'b1, 1'b0, 1'b0, 16'h8001);
		mil(abwf_pkg::KIND_CMD, 1'b1, 1'b1, 1'b0, 16'h7ffe);
		done("mil");
	endtask
	task t_resp;
		re = 1'b1;
		mil(abwf_pkg::KIND_STAT, 1'b1, 1'b0, 1'b0, 16'h4321);
		mil(abwf_pkg::KIND_DATA, 1'b1, 1'b0, 1'b0, 16'h1234);
		re = 1'b0;
		mil(abwf_pkg::KIND_STAT, 1'b0, 1'b0, 1'b0, 16'hf00d);
		done("resp");
	endtask
	task t_err;
		mt = 1'b1;
		re = 1'b1;
		mil(abwf_pkg::KIND_CMD, 1'b0, 1'b1, 1'b1, 16'ha55a);
		mil(abwf_pkg::KIND_STAT, 1'b1, 1'b0, 1'b1, 16'h0f0f);
		done("err");
	endtask
	task t_arinc;
		at = 1'b0;
		for (int s = 0; s < 4; s++) arn({4'h3, 2'(s)}, 32'h8421c3a5 + s, 1'b0, 1'b0);
		at = 1'b1;
		arn(6'h3f, 32'hfedc0123, 1'b0, 1'b0);
		done("arinc");
	endtask
	task t_aerr;
		at = 1'b1;
		tm = '{16'h0102, 16'h0304, 16'h0506};
		arn(6'h09, 32'h13579bdf, 1'b1, 1'b0);
		arn(6'h00, 32'h2468ace0, 1'b0, 1'b1);
		done("arinc_err");
	endtask
	task t_aux;
		re = 1'b1;
		aux(4'h4);
		re = 1'b0;
		aux(4'h4);
		aux(4'h3);
		done("aux");
	endtask
	task t_fifo;
		at = 1'b1;
		stall = 1'b1;
		fork
			begin
				arn(6'h05, 32'h11112222, 1'b0, 1'b0);
				arn(6'h06, 32'h33334444, 1'b0, 1'b0);
				arn(6'h07, 32'h55556666, 1'b0, 1'b0);
			end
			begin
				repeat (60) @(posedge i_clk);
				#1;
				chk({21'h0, rdy}, 24'h0);
				stall = 1'b0;
				slow = 1'b1;
			end
		join
		done("fifo");
		slow = 1'b0;
	endtask
	task end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#2000000;
		n_fail++;
		end_sim;
	end
	initial begin
		{i_clk, rst, vld, mt, at, re, stall, slow} = {2'h1, 3'h0, 5'h0};
		i_mil = '0;
		i_ar = '0;
		i_ax = '0;
		tm = '{16'ha1b2, 16'hc3d4, 16'he5f6};
		repeat (6) @(posedge i_clk);
		#1;
		rst = 1'b0;
		t_mil;
		t_resp;
		t_err;
		t_arinc;
		t_aerr;
		t_aux;
		t_fifo;
		end_sim;
	end
endmodule
`default_nettype wire
